/* shared/pcms_pkg.sv */
// constants and types for the phy config and mii status block
package pcms_pkg;
    // ------------------------------------------------------------
    // clock and heartbeat timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SQE_DELAY_NS = 800;
    localparam int SQE_WIDTH_NS = 1000;
    localparam logic [7:0] SQE_DELAY_CYC =
        8'((SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SQE_WIDTH_CYC =
        8'((SQE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [5:0] REG_CTRL_IDX = 6'h00;
    localparam logic [5:0] REG_STAT_IDX = 6'h01;
    localparam logic [5:0] REG_MDIO_IDX = 6'h02;
    localparam logic [5:0] REG_EXT_IDX = 6'h12;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] EXT_RST = 8'h00;
    localparam int CTRL_SPEED_BIT = 0;
    localparam int CTRL_FDX_BIT = 1;
    localparam int CTRL_ROLE_BIT = 2;
    localparam int CTRL_MDIO_EN_BIT = 3;
    localparam int CTRL_MDIO_VAL_BIT = 4;
    localparam int EXT_INHIBIT_BIT = 2;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_LINK_BIT = 1;
    localparam int STAT_SPEED_BIT = 2;
    localparam int STAT_FDX_BIT = 3;
    localparam int STAT_ROLE_BIT = 4;
    localparam int STAT_SWMODE_BIT = 5;
    localparam int STAT_HM_LSB = 6;
    localparam int STAT_COL_BIT = 8;
    localparam int STAT_CRS_BIT = 9;
    localparam int STAT_RXACT_BIT = 10;
    localparam int MDIO_CAP_W = 16;
    localparam int SYM_W = 10;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HM_MII = 2'b00,
        HM_SYMBOL = 2'b01,
        HM_SERIAL = 2'b10,
        HM_PULSE = 2'b11
    } pcms_host_mode_t;

    typedef enum logic [1:0] {
        HB_IDLE = 2'b00,
        HB_WAIT = 2'b01,
        HB_PULSE = 2'b10
    } pcms_hb_state_t;
endpackage

/* hdl/pcms_heartbeat.sv */
// heartbeat (sqe test) pulse generator after end of transmit
`timescale 1ns/1ps
module pcms_heartbeat (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic enable_i,
    input wire logic tx_en_i,
    output logic sqe_o
);
    import pcms_pkg::*;

    pcms_hb_state_t state_r;
    logic [7:0] cnt_r;
    logic tx_q_r;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_q_r <= 1'b0;
        end else begin
            tx_q_r <= tx_en_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !enable_i) begin
            state_r <= HB_IDLE;
            cnt_r <= 8'h00;
            sqe_o <= 1'b0;
        end else begin
            case (state_r)
                HB_IDLE: begin
                    sqe_o <= 1'b0;
                    if (tx_q_r && !tx_en_i) begin
                        state_r <= HB_WAIT;
                        cnt_r <= SQE_DELAY_CYC;
                    end
                end
                HB_WAIT: begin
                    if (cnt_r <= 8'h01) begin
                        state_r <= HB_PULSE;
                        cnt_r <= SQE_WIDTH_CYC;
                        sqe_o <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                HB_PULSE: begin
                    if (cnt_r <= 8'h01) begin
                        state_r <= HB_IDLE;
                        sqe_o <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= HB_IDLE;
                    sqe_o <= 1'b0;
                end
            endcase
        end
    end

    a_hb_inhibit_quiet:
    assert property (@(posedge clk_i) disable iff (srst_i) !enable_i |=> !sqe_o)
        else $error("heartbeat pulse while disabled");

    a_hb_start_delay:
    assert property (@(posedge clk_i) disable iff (srst_i)
        (state_r == HB_IDLE && tx_q_r && !tx_en_i && enable_i) |=> !sqe_o)
        else $error("heartbeat pulse without delay");
endmodule // pcms_heartbeat

/* hdl/pcms_top.sv */
// strap configuration, mii status, collision and carrier sense
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pcms_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_reset_low_i,
    // straps
    input wire logic config_source_select_i,
    input wire logic host_port_type_i,
    input wire logic serial_or_pulse_select_i,
    input wire logic station_role_select_i,
    input wire logic duplex_select_i,
    input wire logic speed_select_i,
    output logic speed_select_o,
    output logic speed_select_oe_o,
    // line side status
    input wire logic rx_lock_i,
    input wire logic link_ok_i,
    input wire logic signal_detect_i,
    input wire logic serial_link_status_i,
    input wire logic rx_unsquelched_i,
    input wire logic [pcms_pkg::SYM_W-1:0] rx_symbol_i,
    input wire logic rx_symbol_valid_i,
    // mac side
    input wire logic tx_en_i,
    output logic col_o,
    output logic crs_o,
    output logic cipher_lock_o,
    output logic link_up_indicator_o,
    // management
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import pcms_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic srst;
    logic [7:0] ctrl_r;
    logic [7:0] ext_r;
    logic [MDIO_CAP_W-1:0] mdio_cap_r;
    logic mdc_q_r;
    logic mdc_rise;
    logic mdc_fall;
    logic sw_mode;
    logic speed100;
    logic full_dpx;
    logic repeater;
    logic inhibit;
    logic sym_hit;
    logic sym_act_r;
    logic rx_act;
    logic sqe;
    logic hb_enable;
    logic col_nxt;
    logic crs_nxt;
    logic link_nxt;
    pcms_host_mode_t host_mode;
    logic [SYM_W-3:0] far_zero;
    logic [5:0] wb_idx;
    logic wb_req;
    logic [31:0] rd_nxt;
    logic [31:0] stat_w;

    // ------------------------------------------------------------
    // reset
    // ------------------------------------------------------------
    assign srst = rst_i || !chip_reset_low_i;

    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    assign sw_mode = config_source_select_i;
    assign speed100 = sw_mode ? ctrl_r[CTRL_SPEED_BIT] : speed_select_i;
    assign full_dpx = sw_mode ? ctrl_r[CTRL_FDX_BIT] : duplex_select_i;
    assign repeater = ctrl_r[CTRL_ROLE_BIT];
    assign inhibit = ext_r[EXT_INHIBIT_BIT];

    always_comb begin
        if (!host_port_type_i) begin
            host_mode = HM_MII;
        end else if (speed100) begin
            host_mode = HM_SYMBOL;
        end else if (serial_or_pulse_select_i) begin
            host_mode = HM_SERIAL;
        end else begin
            host_mode = HM_PULSE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            speed_select_oe_o <= 1'b0;
            speed_select_o <= 1'b0;
        end else begin
            speed_select_oe_o <= sw_mode;
            speed_select_o <= ctrl_r[CTRL_SPEED_BIT];
        end
    end

    // ------------------------------------------------------------
    // receive activity
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SYM_W - 2; gi++) begin : g_zero
            assign far_zero[gi] = !rx_symbol_i[gi] && !(&rx_symbol_i[SYM_W-1:gi+2]);
        end
    endgenerate

    assign sym_hit = |far_zero;

    always_ff @(posedge clk_i) begin
        if (srst) begin
            sym_act_r <= 1'b0;
        end else if (rx_symbol_valid_i) begin
            sym_act_r <= sym_hit;
        end
    end

    assign rx_act = speed100 ? sym_act_r : rx_unsquelched_i;

    // ------------------------------------------------------------
    // heartbeat test
    // ------------------------------------------------------------
    assign hb_enable = !repeater && !full_dpx && !speed100 && !inhibit;

    pcms_heartbeat u_heartbeat (
        .clk_i(clk_i),
        .srst_i(srst),
        .enable_i(hb_enable),
        .tx_en_i(tx_en_i),
        .sqe_o(sqe)
    );

    // ------------------------------------------------------------
    // collision and carrier sense
    // ------------------------------------------------------------
    always_comb begin
        col_nxt = 1'b0;
        crs_nxt = rx_act;
        if (!full_dpx) begin
            col_nxt = (tx_en_i && rx_act) || sqe;
            if (!repeater) begin
                crs_nxt = rx_act || tx_en_i;
            end
        end
    end

    // registered on clk only; not aligned to rx or tx clocks
    always_ff @(posedge clk_i) begin
        if (srst) begin
            col_o <= 1'b0;
            crs_o <= 1'b0;
        end else begin
            col_o <= col_nxt;
            crs_o <= crs_nxt;
        end
    end

    // ------------------------------------------------------------
    // lock and link status
    // ------------------------------------------------------------
    always_comb begin
        case (host_mode)
            HM_MII: link_nxt = link_ok_i;
            HM_SYMBOL: link_nxt = signal_detect_i;
            HM_SERIAL: link_nxt = serial_link_status_i;
            HM_PULSE: link_nxt = signal_detect_i;
            default: link_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            cipher_lock_o <= 1'b0;
            link_up_indicator_o <= 1'b0;
        end else begin
            cipher_lock_o <= rx_lock_i;
            link_up_indicator_o <= link_nxt;
        end
    end

    // ------------------------------------------------------------
    // management data line
    // ------------------------------------------------------------
    assign mdc_rise = mdc_i && !mdc_q_r;
    assign mdc_fall = !mdc_i && mdc_q_r;

    always_ff @(posedge clk_i) begin
        if (srst) begin
            mdc_q_r <= 1'b0;
            mdio_cap_r <= '0;
        end else begin
            mdc_q_r <= mdc_i;
            if (mdc_rise) begin
                mdio_cap_r <= {mdio_cap_r[MDIO_CAP_W-2:0], mdio_i};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            mdio_oe_o <= 1'b0;
            mdio_o <= 1'b0;
        end else if (mdc_fall) begin
            mdio_oe_o <= ctrl_r[CTRL_MDIO_EN_BIT];
            mdio_o <= ctrl_r[CTRL_MDIO_VAL_BIT] && ctrl_r[CTRL_MDIO_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // wishbone register file
    // ------------------------------------------------------------
    assign wb_idx = wb_adr_i[7:2];
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        stat_w = 32'h0000_0000;
        stat_w[STAT_LOCK_BIT] = cipher_lock_o;
        stat_w[STAT_LINK_BIT] = link_up_indicator_o;
        stat_w[STAT_SPEED_BIT] = speed100;
        stat_w[STAT_FDX_BIT] = full_dpx;
        stat_w[STAT_ROLE_BIT] = repeater;
        stat_w[STAT_SWMODE_BIT] = sw_mode;
        stat_w[STAT_HM_LSB+1:STAT_HM_LSB] = host_mode;
        stat_w[STAT_COL_BIT] = col_o;
        stat_w[STAT_CRS_BIT] = crs_o;
        stat_w[STAT_RXACT_BIT] = rx_act;
    end

    always_comb begin
        case (wb_idx)
            REG_CTRL_IDX: rd_nxt = {24'h00_0000, ctrl_r};
            REG_STAT_IDX: rd_nxt = stat_w;
            REG_MDIO_IDX: rd_nxt = {16'h0000, mdio_cap_r};
            REG_EXT_IDX: rd_nxt = {24'h00_0000, ext_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // role defaults to the strap while in reset
    always_ff @(posedge clk_i) begin
        if (srst) begin
            ctrl_r <= CTRL_RST;
            ctrl_r[CTRL_ROLE_BIT] <= station_role_select_i;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_idx == REG_CTRL_IDX) begin
            ctrl_r <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            ext_r <= EXT_RST;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_idx == REG_EXT_IDX) begin
            ext_r <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_col_fdx_low:
    assert property (@(posedge clk_i) disable iff (srst) full_dpx |=> !col_o)
        else $error("collision in full duplex");

    a_col_on_overlap:
    assert property (@(posedge clk_i) disable iff (srst)
        (!full_dpx && tx_en_i && rx_act) |=> col_o)
        else $error("no collision on tx and rx overlap");

    a_crs_half_tx:
    assert property (@(posedge clk_i) disable iff (srst)
        (!full_dpx && !repeater && tx_en_i) |=> crs_o)
        else $error("no carrier sense on own transmit");

    a_crs_rx_only:
    assert property (@(posedge clk_i) disable iff (srst)
        ((full_dpx || repeater) && !rx_act) |=> !crs_o)
        else $error("carrier sense from transmit in full duplex or repeater");

    a_idle_quiet:
    assert property (@(posedge clk_i) disable iff (srst)
        (!tx_en_i && !rx_act && !sqe) |=> (!crs_o && !col_o))
        else $error("col or crs high while idle");

    a_speed_pin_dir:
    assert property (@(posedge clk_i) disable iff (srst)
        1'b1 |=> (speed_select_oe_o == $past(config_source_select_i)))
        else $error("speed pin direction wrong for mode");

    a_link_mii_map:
    assert property (@(posedge clk_i) disable iff (srst)
        (host_mode == HM_MII) |=> (link_up_indicator_o == $past(link_ok_i)))
        else $error("link indicator not link status in mii");

    a_lock_follow:
    assert property (@(posedge clk_i) disable iff (srst)
        1'b1 |=> (cipher_lock_o == $past(rx_lock_i)))
        else $error("lock output does not follow lock");

    a_sym_detect:
    assert property (@(posedge clk_i) disable iff (srst)
        (rx_symbol_valid_i && sym_hit) |=> sym_act_r)
        else $error("symbol with split zeros not seen as activity");

    a_mdio_on_fall:
    assert property (@(posedge clk_i) disable iff (srst)
        $changed(mdio_oe_o) |-> $past(mdc_fall))
        else $error("mdio enable changed away from mdc fall");

    a_reset_quiet:
    assert property (@(posedge clk_i) !chip_reset_low_i |=> (!col_o && !crs_o && !wb_ack_o))
        else $error("outputs active during chip reset");
endmodule // pcms_top

/* test/pcms_mac_model.sv */
// mac and station manager model facing the block
`timescale 1ns/1ps
module pcms_mac_model (
    input wire logic clk_i,
    input wire logic col_i,
    input wire logic crs_i,
    input wire logic mdio_line_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    logic [1:0] col_s_r;
    logic [1:0] crs_s_r;
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        mdc_o = 1'b0; // mdc still between frames
        mdio_o = 1'b0;
        mdio_oe_o = 1'b0;
    end
    // col and crs are not aligned to rx or tx clocks, so double-flop them
    always_ff @(posedge clk_i) begin
        col_s_r <= {col_s_r[0], col_i};
        crs_s_r <= {crs_s_r[0], crs_i};
    end
    // ------------------------------------------------------------
    // management transfers
    // ------------------------------------------------------------
    // one mdc period, line sampled just after the rise
    task automatic mdc_cycle(output logic b);
        repeat (3) @(posedge clk_i);
        mdc_o <= 1'b1;
        @(posedge clk_i);
        b = mdio_line_i;
        repeat (3) @(posedge clk_i);
        mdc_o <= 1'b0;
    endtask
    // msb first, data held across each rise
    task automatic send_word(input logic [15:0] w);
        logic b;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_i);
            mdio_oe_o <= 1'b1;
            mdio_o <= w[i];
            mdc_cycle(b);
        end
        repeat (4) @(posedge clk_i);
        mdio_oe_o <= 1'b0; // released, pull-up takes the line
    endtask
endmodule // pcms_mac_model

/* test/pcms_top_tb_top.sv */
// self-checking bench for the phy config and mii status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
end
module pcms_top_tb_top;
    import pcms_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, chip_reset_low = 1'b1;
    logic cfg_sw = 1'b0, host_stream = 1'b0, ser_pulse = 1'b0, role_pin = 1'b1;
    logic fdx = 1'b0, spd = 1'b0, lock = 1'b0, link = 1'b0, sdet = 1'b0, sls = 1'b0;
    logic rxu = 1'b0, symv = 1'b0, txen = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] sym = 10'h000;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, rq;
    logic spd_o, spd_oe, col, crs, lck, lnk, md_o, md_oe, ack, mdc, mm_o, mm_oe, mline;
    logic [9:0] corner [4] = '{10'h3f6, 10'h3fc, 10'h1fe, 10'h3ff};
    int fail_count = 0, n_checks = 0, cyc_cnt = 0, rnd;
    assign mline = md_oe ? md_o : (mm_oe ? mm_o : 1'b1); // pull-up when idle
    always #20 clk_i = ~clk_i; // 25 MHz reference
    pcms_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .chip_reset_low_i(chip_reset_low),
        .config_source_select_i(cfg_sw), .host_port_type_i(host_stream),
        .serial_or_pulse_select_i(ser_pulse), .station_role_select_i(role_pin),
        .duplex_select_i(fdx), .speed_select_i(spd), .speed_select_o(spd_o),
        .speed_select_oe_o(spd_oe), .rx_lock_i(lock), .link_ok_i(link),
        .signal_detect_i(sdet), .serial_link_status_i(sls), .rx_unsquelched_i(rxu),
        .rx_symbol_i(sym), .rx_symbol_valid_i(symv), .tx_en_i(txen), .col_o(col),
        .crs_o(crs), .cipher_lock_o(lck), .link_up_indicator_o(lnk), .mdc_i(mdc),
        .mdio_i(mline), .mdio_o(md_o), .mdio_oe_o(md_oe), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack)
    );
    pcms_mac_model i_mac (
        .clk_i(clk_i), .col_i(col), .crs_i(crs), .mdio_line_i(mline),
        .mdc_o(mdc), .mdio_o(mm_o), .mdio_oe_o(mm_oe)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // waits on ack with no cycle count of its own; a hang ends at the bench timeout
    task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    function automatic logic nadj(input logic [9:0] s);
        for (int i = 0; i < 10; i++)
            for (int j = i + 2; j < 10; j++)
                if (!s[i] && !s[j]) return 1'b1;
        return 1'b0;
    endfunction
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [3:0] v;
        logic [1:0] m;
        logic [9:0] s;
        logic [15:0] w;
        logic b;
        int hb;
        rnd = $urandom(22);
        tick(8);
        rst_i <= 1'b0;
        tick(2);
        `CHK("col_idle", 1'b0, col);
        `CHK("spd_oe_hw", 1'b0, spd_oe);
        wb(1'b0, REG_CTRL_IDX, 32'h0);
        `CHK("ctrl_role", 32'h4, rq);
        wb(1'b0, REG_EXT_IDX, 32'h0);
        `CHK("ext_rst", 32'h0, rq);
        wb(1'b1, 6'h3f, 32'hff);
        wb(1'b0, 6'h3f, 32'h0);
        `CHK("unmapped", 32'h0, rq);
        wb(1'b1, REG_CTRL_IDX, 32'h13);
        chip_reset_low <= 1'b0;
        tick(2);
        chip_reset_low <= 1'b1;
        wb(1'b0, REG_CTRL_IDX, 32'h0);
        `CHK("chip_rst", 32'h4, rq);
        wb(1'b1, REG_CTRL_IDX, 32'h0);
        wb(1'b1, REG_EXT_IDX, 32'h4);
        for (int k = 0; k < 20; k++) begin
            m = 2'($urandom_range(3));
            v = 4'($urandom);
            {lock, link, sdet, sls} <= v;
            host_stream <= (m != HM_MII);
            spd <= (m == HM_SYMBOL) | ((m == HM_MII) & v[0]);
            ser_pulse <= (m == HM_SERIAL);
            tick(3);
            `CHK("lock", v[3], lck);
            `CHK("link", (m == HM_MII) ? v[2] : (m == HM_SERIAL) ? v[0] : v[1], lnk);
            wb(1'b0, REG_STAT_IDX, 32'h0);
            `CHK("host_mode", m, rq[7:6]);
            `CHK("sw_mode", 1'b0, rq[STAT_SWMODE_BIT]);
        end
        host_stream <= 1'b0;
        spd <= 1'b0;
        cfg_sw <= 1'b1;
        wb(1'b1, REG_CTRL_IDX, 32'h3);
        tick(2);
        `CHK("spd_oe_sw", 1'b1, spd_oe);
        `CHK("spd_out", 1'b1, spd_o);
        wb(1'b0, REG_STAT_IDX, 32'h0);
        `CHK("sw_mode", 1'b1, rq[STAT_SWMODE_BIT]);
        `CHK("sw_fdx", 1'b1, rq[STAT_FDX_BIT]);
        `CHK("sw_speed", 1'b1, rq[STAT_SPEED_BIT]);
        cfg_sw <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            wb(1'b1, REG_CTRL_IDX, {29'h0, k[1], 2'h0});
            fdx <= k[0];
            txen <= k[2];
            rxu <= k[3];
            tick(3);
            `CHK("col", k[2] & k[3] & !k[0], col);
            `CHK("crs", k[3] | (k[2] & !k[0] & !k[1]), crs);
            txen <= 1'b0;
            rxu <= 1'b0;
            tick(3);
            `CHK("col_end", 1'b0, col);
            `CHK("crs_end", 1'b0, crs);
            `CHK("col_sync", k[2] & k[3] & !k[0], i_mac.col_s_r[1]);
            `CHK("crs_sync", k[3] | (k[2] & !k[0] & !k[1]), i_mac.crs_s_r[1]);
        end
        fdx <= 1'b0;
        wb(1'b1, REG_CTRL_IDX, 32'h0);
        for (int inh = 0; inh < 2; inh++) begin
            wb(1'b1, REG_EXT_IDX, inh ? 32'h4 : 32'h0);
            txen <= 1'b1;
            tick(4);
            txen <= 1'b0;
            hb = 0;
            repeat (80) begin
                @(posedge clk_i);
                if (col === 1'b1) hb++;
            end
            `CHK("sqe_len", inh ? 0 : int'(SQE_WIDTH_CYC), hb);
        end
        spd <= 1'b1;
        txen <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            s = (k < 4) ? corner[k] : 10'($urandom);
            sym <= s;
            symv <= 1'b1;
            tick(1);
            symv <= 1'b0;
            tick(3);
            `CHK("sym_col", nadj(s), col);
        end
        sym <= 10'h3ff;
        symv <= 1'b1;
        tick(1);
        symv <= 1'b0;
        txen <= 1'b0;
        tick(4);
        `CHK("sym_idle", 2'h0, {col, crs});
        w = 16'($urandom);
        i_mac.send_word(w);
        wb(1'b0, REG_MDIO_IDX, 32'h0);
        `CHK("mdio_cap", w, rq[15:0]);
        wb(1'b1, REG_CTRL_IDX, 32'h8);
        i_mac.mdc_cycle(b);
        i_mac.mdc_cycle(b);
        `CHK("mdio_drv", 2'h2, {md_oe, b});
        wb(1'b1, REG_CTRL_IDX, 32'h0);
        i_mac.mdc_cycle(b);
        i_mac.mdc_cycle(b);
        `CHK("mdio_rel", 2'h1, {md_oe, b});
        finish_test();
    end
endmodule // pcms_top_tb_top
